//--- src/cfg_crc_defs.svh
// constants for the configuration memory crc monitor
`ifndef CFG_CRC_DEFS_SVH
`define CFG_CRC_DEFS_SVH
`define CRC_WIDTH 32
`define CRC_POLY 32'h04c11db7
`define CRC_INIT 32'hffffffff
`define CRC_SIG_RESET 32'h00000000
`define CRC_REF_RESET 32'h00000000
`define JTAG_IR_WIDTH 10
`define JTAG_IR_STORE_LOAD 10'h015
`define DIV_N_WIDTH 4
`define DIV_N_MAX 4'h8
`define OSC_FREQ_MHZ 80
`define CLK_FREQ_MHZ 25
`define CELL_WORDS_DEFAULT 64
`endif

//--- src/cfg_crc_pkg.sv
// types shared by the configuration memory crc monitor
package cfg_crc_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SEED,
    ST_SCAN,
    ST_DONE
  } scan_state_e;
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jtag_in_s;
endpackage

//--- src/crc32_step.sv
// one-bit serial crc32 update, polynomial of the ieee 802 family
`include "cfg_crc_defs.svh"
module crc32_step #(
  parameter int WIDTH = `CRC_WIDTH
) (
  // state and data bit
  input wire logic [WIDTH-1:0] crc_in,
  input wire logic data_bit,
  // updated state
  output logic [WIDTH-1:0] crc_out
);
  wire feedback = crc_in[WIDTH-1] ^ data_bit;
  wire [WIDTH-1:0] shifted = {crc_in[WIDTH-2:0], 1'b0};
  wire [WIDTH-1:0] poly = `CRC_POLY;
  assign crc_out = feedback ? (shifted ^ poly) : shifted;
endmodule // crc32_step

//--- src/config_memory_crc_monitor.sv
// user-mode crc monitor of the configuration memory with a jtag reference scan chain
`include "cfg_crc_defs.svh"
// Overview of operation
// - two 32-bit registers: signature and reference
// - signature holds compare result, zero when clean
// - fault flag high when signature non-zero
// - reference loaded at end of configuration
// - reference fed to compute-and-compare circuit
// - load instruction makes reference a scan chain
// - load instruction overwrites reference for injection
// - checking never halts during the instruction
// - checking starts itself on entering user mode
// - flag low until a pass finds corruption
// - raised flag stays high through next pass
// - clean pass returns flag low, no latching
// - passes repeat until device reset
// - checker clocked by divided configuration oscillator
// - divisor two to the n, n 0..8
// - pass time scales with memory size, divisor
// - instruction 00 0001 0101 puts reference between tdi, tdo
// - crc uses the ieee 802 32-bit polynomial
module config_memory_crc_monitor #(
  parameter int CELL_WORDS = `CELL_WORDS_DEFAULT,
  parameter int WORD_WIDTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // configuration controller
  input wire logic check_enable,
  input wire logic user_mode,
  input wire logic config_done_pulse,
  input wire logic [`CRC_WIDTH-1:0] precomputed_crc,
  input wire logic [`DIV_N_WIDTH-1:0] div_n,
  // configuration memory read port, combinational on the same clock
  output logic [$clog2(CELL_WORDS)-1:0] cell_addr,
  input wire logic [WORD_WIDTH-1:0] cell_data,
  // jtag test access, pins from the host
  input wire cfg_crc_pkg::jtag_in_s jtag_in,
  input wire logic [`JTAG_IR_WIDTH-1:0] jtag_ir,
  input wire logic jtag_shift_dr,
  output logic jtag_tdo,
  output logic jtag_tdo_oe,
  // error flag pin, open drain
  output logic crc_fault_o,
  output logic crc_fault_oe,
  // state visible to user logic
  output logic [`CRC_WIDTH-1:0] crc_compare_signature,
  output logic pass_done
);
  localparam int AW = $clog2(CELL_WORDS);
  localparam int BW = $clog2(WORD_WIDTH);
  localparam logic [AW-1:0] LAST_WORD = AW'(CELL_WORDS - 1);
  localparam logic [BW-1:0] LAST_BIT = BW'(WORD_WIDTH - 1);

  // timing at a glance:
  //   a tck edge on the pin acts three clocks later, after two sync flops and the edge detect
  //   tdo and its enable move only on a detected tck fall
  //   a pass is one seed cycle, one scan step per tick and one done cycle
  //   signature, flag and pass_done all update on the edge that ends the done cycle
  //   nothing here waits on the chain, so reloading never stalls checking

  // pin synchronisers; stage one is read only by stage two
  logic [2:0] jtag_s1_r;
  logic [2:0] jtag_s2_r;
  logic [2:0] jtag_s3_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      jtag_s1_r <= 3'h0;
      jtag_s2_r <= 3'h0;
      jtag_s3_r <= 3'h0;
    end else begin
      jtag_s1_r <= {jtag_in.tck, jtag_in.tms, jtag_in.tdi};
      jtag_s2_r <= jtag_s1_r;
      jtag_s3_r <= jtag_s2_r;
    end
  end
  wire tck_rise = jtag_s2_r[2] & ~jtag_s3_r[2];
  wire tck_fall = ~jtag_s2_r[2] & jtag_s3_r[2];
  wire tdi_sync = jtag_s2_r[0];

  // the tap's instruction and shift state live on tck, so they are synchronised too;
  // both stay still while bits move, so a word-wide double flop is safe here
  logic [`JTAG_IR_WIDTH-1:0] ir_s1_r;
  logic [`JTAG_IR_WIDTH-1:0] ir_s2_r;
  logic shift_s1_r;
  logic shift_s2_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_s1_r <= '0;
      ir_s2_r <= '0;
      shift_s1_r <= 1'b0;
      shift_s2_r <= 1'b0;
    end else begin
      ir_s1_r <= jtag_ir;
      ir_s2_r <= ir_s1_r;
      shift_s1_r <= jtag_shift_dr;
      shift_s2_r <= shift_s1_r;
    end
  end

  // the instruction register is held by the tap outside this block
  wire ir_is_store_load = (ir_s2_r == `JTAG_IR_STORE_LOAD);
  wire store_sel = ir_is_store_load && user_mode;
  wire shift_en = store_sel && shift_s2_r;
  wire shift_step = shift_en && tck_rise;

  // reference store: parallel load after configuration, serial chain under jtag
  logic [`CRC_WIDTH-1:0] ref_r;
  logic [`CRC_WIDTH-1:0] ref_nxt;
  // a parallel load in the same cycle as a shift wins, so the end of
  // configuration always leaves the precomputed reference behind
  wire [`CRC_WIDTH-1:0] serial_word = {tdi_sync, ref_r[`CRC_WIDTH-1:1]};
  always_comb begin
    ref_nxt = ref_r;
    if (config_done_pulse) begin
      ref_nxt = precomputed_crc;
    end else if (shift_step) begin
      ref_nxt = serial_word;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_r <= `CRC_REF_RESET;
    end else begin
      ref_r <= ref_nxt;
    end
  end

  // tdo changes on the falling tck edge, as a tap does; holding it between
  // falls keeps the host's rising-edge sample clear of our own shift
  logic tdo_r;
  logic tdo_nxt;
  logic tdo_oe_r;
  logic tdo_oe_nxt;
  always_comb begin
    tdo_nxt = tdo_r;
    tdo_oe_nxt = tdo_oe_r;
    if (tck_fall) begin
      tdo_nxt = ref_r[0];
      tdo_oe_nxt = shift_en;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tdo_r <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else begin
      tdo_r <= tdo_nxt;
      tdo_oe_r <= tdo_oe_nxt;
    end
  end
  assign jtag_tdo = tdo_r;
  assign jtag_tdo_oe = tdo_oe_r;

  // checker rate: one-cycle enable every two to the n clocks; a free-running
  // counter keeps the enable regular even when n changes mid pass
  logic [8:0] div_cnt_r;
  logic [8:0] div_cnt_nxt;
  // exponents above the top one run at the slowest rate rather than wrapping
  wire n_too_big = (div_n > `DIV_N_MAX);
  wire [3:0] n_clamped = n_too_big ? `DIV_N_MAX : div_n;
  wire [9:0] div_span = 10'h001 << n_clamped;
  wire [8:0] div_mask = 9'(div_span - 10'h001);
  wire tick = (div_cnt_r & div_mask) == 9'h000;
  assign div_cnt_nxt = div_cnt_r + 9'h001;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_r <= 9'h000;
    end else begin
      div_cnt_r <= div_cnt_nxt;
    end
  end

  // pass sequencer: one bit of memory per tick, so pass time grows with size and divisor;
  // the walk is seed, then every bit of every word from bit 0 of word 0 upward,
  // then one done cycle, then seed again for as long as the device runs
  cfg_crc_pkg::scan_state_e state_r;
  cfg_crc_pkg::scan_state_e state_nxt;
  logic [AW-1:0] addr_r;
  logic [BW-1:0] bit_r;
  logic [`CRC_WIDTH-1:0] crc_r;
  logic [`CRC_WIDTH-1:0] crc_stepped;
  logic [`CRC_WIDTH-1:0] sig_r;
  logic fault_r;
  logic done_r;
  logic [AW-1:0] addr_nxt;
  logic [BW-1:0] bit_nxt;
  logic [`CRC_WIDTH-1:0] crc_nxt;
  logic [`CRC_WIDTH-1:0] sig_nxt;
  logic fault_nxt;
  logic fault_oe_r;
  logic fault_oe_nxt;
  logic done_nxt;
  logic [`CRC_WIDTH-1:0] cmp_ref_r;
  logic [`CRC_WIDTH-1:0] cmp_ref_nxt;

  crc32_step #(
    .WIDTH(`CRC_WIDTH)
  ) u_step (
    .crc_in(crc_r),
    .data_bit(cell_data[bit_r]),
    .crc_out(crc_stepped)
  );

  wire last_bit = (addr_r == LAST_WORD) && (bit_r == LAST_BIT);
  wire scan_last = tick && last_bit;
  wire start_ok = check_enable && user_mode;

  // each pass works against the reference in force when it began, so a reload
  // through the chain mid pass only shows from the following pass on
  always_comb begin
    cmp_ref_nxt = cmp_ref_r;
    if (state_r == cfg_crc_pkg::ST_SEED) begin
      cmp_ref_nxt = ref_r;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_ref_r <= `CRC_REF_RESET;
    end else begin
      cmp_ref_r <= cmp_ref_nxt;
    end
  end
  wire [`CRC_WIDTH-1:0] compare = crc_r ^ cmp_ref_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      cfg_crc_pkg::ST_IDLE: begin
        if (start_ok) begin
          state_nxt = cfg_crc_pkg::ST_SEED;
        end
      end
      cfg_crc_pkg::ST_SEED: begin
        state_nxt = cfg_crc_pkg::ST_SCAN;
      end
      cfg_crc_pkg::ST_SCAN: begin
        if (scan_last) begin
          state_nxt = cfg_crc_pkg::ST_DONE;
        end
      end
      cfg_crc_pkg::ST_DONE: begin
        state_nxt = cfg_crc_pkg::ST_SEED;
      end
      default: begin
        state_nxt = cfg_crc_pkg::ST_IDLE;
      end
    endcase
  end

  // the jtag chain never stalls this sequencer, so checking goes on while loading
  wire scan_step = (state_r == cfg_crc_pkg::ST_SCAN) && tick;
  wire word_end = (bit_r == LAST_BIT);
  always_comb begin
    addr_nxt = addr_r;
    bit_nxt = bit_r;
    crc_nxt = crc_r;
    if (state_r == cfg_crc_pkg::ST_SEED) begin
      addr_nxt = '0;
      bit_nxt = '0;
      crc_nxt = `CRC_INIT;
    end else if (scan_step) begin
      crc_nxt = crc_stepped;
      if (word_end) begin
        bit_nxt = '0;
        addr_nxt = addr_r + 1'b1;
      end else begin
        bit_nxt = bit_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= cfg_crc_pkg::ST_IDLE;
      addr_r <= '0;
      bit_r <= '0;
      crc_r <= `CRC_INIT;
    end else begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
      bit_r <= bit_nxt;
      crc_r <= crc_nxt;
    end
  end

  // signature and flag change only when a pass completes and are held across the
  // next pass; a clean pass clears them again, nothing is latched
  wire pass_end = (state_r == cfg_crc_pkg::ST_DONE);
  wire sig_fault = (compare != `CRC_SIG_RESET);
  always_comb begin
    sig_nxt = sig_r;
    fault_nxt = fault_r;
    fault_oe_nxt = fault_oe_r;
    if (pass_end) begin
      sig_nxt = compare;
      fault_nxt = sig_fault;
      fault_oe_nxt = ~sig_fault;
    end
  end
  assign done_nxt = pass_end;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sig_r <= `CRC_SIG_RESET;
      fault_r <= 1'b0;
      fault_oe_r <= 1'b1;
      done_r <= 1'b0;
    end else begin
      sig_r <= sig_nxt;
      fault_r <= fault_nxt;
      fault_oe_r <= fault_oe_nxt;
      done_r <= done_nxt;
    end
  end

  assign crc_compare_signature = sig_r;
  assign pass_done = done_r;
  // open drain: the pin is pulled up externally and driven low only when clean;
  // the enable has its own flop so the pin never sees a gate between register and pad
  assign crc_fault_o = fault_r;
  assign crc_fault_oe = fault_oe_r;
  assign cell_addr = addr_r;
endmodule // config_memory_crc_monitor

//--- dv/crc_monitor_assertions.sv
// assertion checker for the configuration memory crc monitor
`include "cfg_crc_defs.svh"
module crc_monitor_checker (
  // watched ports
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`DIV_N_WIDTH-1:0] div_n,
  input wire cfg_crc_pkg::jtag_in_s jtag_in,
  input wire logic jtag_tdo,
  input wire logic jtag_tdo_oe,
  input wire logic crc_fault_o,
  input wire logic crc_fault_oe,
  input wire logic [`CRC_WIDTH-1:0] crc_compare_signature,
  input wire logic pass_done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence quiet_pass;
    ##1 !pass_done [*8];
  endsequence
  chk_flag_sig: assert property (crc_fault_o == (crc_compare_signature != 0)) else $error("flag vs sig");
  chk_drain_oe: assert property (crc_fault_oe != crc_fault_o) else $error("drain enable");
  chk_sig_end: assert property ($changed(crc_compare_signature) |-> pass_done) else $error("sig mid pass");
  chk_flag_end: assert property ($changed(crc_fault_o) |-> pass_done) else $error("flag mid pass");
  chk_pass_gap: assert property (pass_done |-> quiet_pass) else $error("passes too close");
  chk_pass_again: assert property (pass_done && div_n == 0 |-> ##[60:80] (pass_done || div_n != 0))
    else $error("pass not repeated");
  chk_tdo_fall: assert property ($changed(jtag_tdo) |-> !jtag_in.tck && !$past(jtag_in.tck))
    else $error("tdo off tck fall");
  chk_oe_fall: assert property ($changed(jtag_tdo_oe) |-> !jtag_in.tck && !$past(jtag_in.tck))
    else $error("tdo enable off tck fall");
endmodule // crc_monitor_checker
bind config_memory_crc_monitor crc_monitor_checker i_crc_monitor_checker (.clk, .rst_n, .div_n, .jtag_in,
  .jtag_tdo, .jtag_tdo_oe, .crc_fault_o, .crc_fault_oe, .crc_compare_signature, .pass_done);

//--- dv/cfg_cell_model.sv
// far side model: configuration memory cells and pulled-up fault line
module cfg_cell_model (
  // ports
  input wire logic cell_addr,
  input wire logic [63:0] cells,
  output logic [31:0] cell_data,
  input wire logic crc_fault_oe,
  output logic fault_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  assign cell_data = cell_addr ? cells[63:32] : cells[31:0];
  // released line is pulled up, so a fault reads high
  assign fault_pin = crc_fault_oe ? 1'b0 : 1'b1;
endmodule // cfg_cell_model

//--- dv/test_config_memory_crc_monitor.sv
// self-checking bench for the configuration memory crc monitor
`include "cfg_crc_defs.svh"
module test_config_memory_crc_monitor;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, check_enable, user_mode, config_done_pulse, jtag_shift_dr, jtag_tdo, jtag_tdo_oe;
  logic crc_fault_o, crc_fault_oe, pass_done, cell_addr, fault_pin;
  logic [31:0] precomputed_crc, cell_data, crc_compare_signature, good, bad;
  logic [3:0] div_n;
  logic [9:0] jtag_ir;
  logic [63:0] cells;
  cfg_crc_pkg::jtag_in_s jtag_in;
  int error_cnt = 0;
  int comparisons = 0;
  int c;
  config_memory_crc_monitor #(.CELL_WORDS(2)) i_config_memory_crc_monitor (.clk, .rst_n, .check_enable,
    .user_mode, .config_done_pulse, .precomputed_crc, .div_n, .cell_addr, .cell_data, .jtag_in, .jtag_ir,
    .jtag_shift_dr, .jtag_tdo, .jtag_tdo_oe, .crc_fault_o, .crc_fault_oe, .crc_compare_signature, .pass_done);
  cfg_cell_model i_cfg_cell_model (.cell_addr, .cells, .cell_data, .crc_fault_oe, .fault_pin);
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  function automatic logic [31:0] crc_of(logic [63:0] m);
    logic [31:0] r;
    r = `CRC_INIT;
    for (int i = 0; i < 64; i++)
      r = {r[30:0], 1'b0} ^ (r[31] ^ m[i] ? `CRC_POLY : 32'h0);
    return r;
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // c ends as the pass length; the first of two waits may see a pass that straddled a change
  task automatic wait_pass();
    c = 1; // counts the cycle spent after the previous pulse, so c is the full period
    while (pass_done !== 1'b1 && c < 20000) begin
      tick(1);
      c++;
    end
    tick(1);
  endtask
  task automatic expect_ref(logic [31:0] ref_v);
    repeat (2) wait_pass();
    check("signature", crc_compare_signature, crc_of(cells) ^ ref_v);
    check("fault pin", fault_pin, (crc_of(cells) ^ ref_v) != 0);
  endtask
  task automatic jtag_load(logic [31:0] v, logic [31:0] old);
    jtag_ir = `JTAG_IR_STORE_LOAD;
    jtag_shift_dr = 1;
    for (int i = 0; i < 32; i++) begin
      jtag_in.tdi = v[i];
      jtag_in.tck = 1;
      tick(4);
      jtag_in.tck = 0;
      tick(4);
      check("tdo", {jtag_tdo_oe, jtag_tdo}, {1'b1, i < 31 ? old[i + 1] : v[0]});
    end
    jtag_shift_dr = 0;
  endtask
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  initial begin
    #2000000;
    check("watchdog", 0, 1);
    results();
  end
  initial begin
    void'($urandom(32'h4300));
    cells = {$urandom, $urandom};
    good = crc_of(cells);
    bad = $urandom;
    {rst_n, user_mode, config_done_pulse, jtag_shift_dr, jtag_in, jtag_ir, div_n} = '0;
    check_enable = 1;
    precomputed_crc = good;
    tick(16);
    rst_n = 1;
    check("reset", crc_compare_signature | fault_pin, 0);
    check("tdo idle", {jtag_tdo_oe, jtag_tdo}, 2'b00);
    user_mode = 1;
    config_done_pulse = 1;
    tick(1);
    config_done_pulse = 0;
    expect_ref(good);
    jtag_load(bad, good);
    expect_ref(bad);
    jtag_load(good, bad);
    expect_ref(good);
    cells[$urandom % 64] ^= 1'b1;
    expect_ref(good);
    for (int n = 2; n >= 0; n--) begin
      div_n = n[3:0];
      repeat (2) wait_pass();
      check("pass length", c >= (64 << n) && c <= (64 << n) + 8, 1);
    end
    div_n = 4'h9 + 4'($urandom % 7);
    repeat (2) wait_pass();
    check("clamped pass", c >= (64 << 8) && c <= (64 << 8) + 8, 1);
    results();
  end
endmodule // test_config_memory_crc_monitor
